// ==== logic/dps_pkg.sv ====
// Shared constants and types for the drive profile state machine and its host end.
`default_nettype none
package dps_pkg;
  // ---------------------------------------------------------------
  // Object dictionary indices
  // ---------------------------------------------------------------
  localparam logic [15:0] IDX_DRIVE_COMMAND_WORD = 16'h6040;
  localparam logic [15:0] IDX_DRIVE_STATE_WORD = 16'h6041;
  localparam logic [15:0] IDX_TARGET_SPEED_RPM = 16'h6042;
  localparam logic [15:0] IDX_SPEED_DEMAND = 16'h6043;
  localparam logic [15:0] IDX_SPEED_ACTUAL = 16'h6044;
  localparam logic [15:0] IDX_ACCEL_RAMP_MS = 16'h604F;
  localparam logic [15:0] IDX_DECEL_TIME_MS = 16'h6050;
  localparam logic [15:0] IDX_OPERATING_MODE_SELECT = 16'h6060;
  localparam logic [15:0] IDX_OPERATING_MODE_READBACK = 16'h6061;
  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [7:0] RST_MODE = 8'h00;
  // ---------------------------------------------------------------
  // Command word fields and command codes
  // ---------------------------------------------------------------
  localparam int CW_ENABLE_VOLTAGE = 1;
  localparam int CW_QUICK_STOP = 2;
  localparam int CW_ENABLE_OPERATION = 3;
  localparam int CW_MODE_LSB = 4;
  localparam int CW_FAULT_RESET = 7;
  localparam int CW_HALT = 8;
  localparam logic [3:0] CMD_SHUTDOWN = 4'h6;
  localparam logic [3:0] CMD_SWITCH_ON = 4'hE;
  localparam logic [3:0] CMD_SWITCH_ON_ALT = 4'h7;
  localparam logic [3:0] CMD_ENABLE_OP = 4'hF;
  localparam logic [2:0] VL_RUN = 3'h7;
  localparam logic [2:0] VL_HOLD = 3'h5;
  localparam logic [7:0] MODE_VELOCITY = 8'h02;
  // ---------------------------------------------------------------
  // State word fields
  // ---------------------------------------------------------------
  localparam int SW_READY = 0;
  localparam int SW_SWITCHED_ON = 1;
  localparam int SW_OP_ENABLED = 2;
  localparam int SW_FAULT = 3;
  localparam int SW_VOLTAGE = 4;
  localparam int SW_QUICK_STOP = 5;
  localparam int SW_ON_DISABLED = 6;
  localparam int SW_WARNING = 7;
  localparam int SW_REMOTE = 9;
  localparam int SW_TARGET_REACHED = 10;
  // ---------------------------------------------------------------
  // Warning and fault codes
  // ---------------------------------------------------------------
  localparam logic [7:0] CODE_NONE = 8'h00;
  localparam logic [7:0] CODE_COMM_TIMEOUT = 8'h51;
  localparam logic [7:0] CODE_CARD_DISCONNECT = 8'h59;
  localparam logic [7:0] CODE_SYNC_WARNING = 8'h6F;
  localparam logic [7:0] CODE_SYNC_FAULT = 8'hA1;
  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int US_NS = 1000;
  localparam int US_CYCLES = US_NS / CLK_PERIOD_NS;
  localparam int INIT_US = 10;
  localparam int INIT_CYCLES = INIT_US * US_CYCLES;
  localparam int COMM_TIMEOUT_MS = 100;
  localparam int COMM_TIMEOUT_CYCLES = COMM_TIMEOUT_MS * 1000 * US_CYCLES;
  localparam int SYNC_TIMEOUT_MS = 2;
  localparam int SYNC_TIMEOUT_CYCLES = SYNC_TIMEOUT_MS * 1000 * US_CYCLES;
  localparam int SYNC_PERIOD_US = 1000;
  localparam int SYNC_PERIOD_CYCLES = SYNC_PERIOD_US * US_CYCLES;
  // ---------------------------------------------------------------
  // Drive states
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_START = 4'h0,
    ST_NOT_READY = 4'h1,
    ST_ON_DISABLED = 4'h2,
    ST_READY = 4'h3,
    ST_SWITCHED_ON = 4'h4,
    ST_OP_ENABLED = 4'h5,
    ST_QUICK_STOP = 4'h6,
    ST_FAULT_REACTION = 4'h7,
    ST_FAULT = 4'h8
  } dps_state_t;
endpackage
`default_nettype wire

// ==== logic/dps_link_if.sv ====
// Object dictionary transport between the host end and the drive end.
`default_nettype none
interface dps_link_if;
  logic req;
  logic we;
  logic [15:0] index;
  logic [15:0] wdata;
  logic ack;
  logic err;
  logic [15:0] rdata;
  logic sync_pulse;

  // Host end issues accesses and sync packets.
  modport host (output req, we, index, wdata, sync_pulse, input ack, err, rdata);
  // Drive end answers accesses.
  modport drive (input req, we, index, wdata, sync_pulse, output ack, err, rdata);
endinterface
`default_nettype wire

// ==== logic/dps_drive_end.sv ====
// Drive end: object dictionary, power state machine, velocity ramp and supervision.
`default_nettype none
module dps_drive_end #(
  parameter int COMM_TIMEOUT_CYCLES = dps_pkg::COMM_TIMEOUT_CYCLES,
  parameter int SYNC_TIMEOUT_CYCLES = dps_pkg::SYNC_TIMEOUT_CYCLES
) (
  input wire logic ref_clk,
  input wire logic resetn,
  dps_link_if.drive link,
  input wire logic card_present,
  input wire logic sync_mode_en,
  input wire logic cmd_src_card,
  input wire logic [15:0] speed_feedback,
  output logic pwm_enable,
  output logic motor_excited,
  output logic [15:0] speed_cmd,
  output logic [3:0] drive_state,
  output logic [7:0] event_code
);
  dps_pkg::dps_state_t state;
  dps_pkg::dps_state_t next_state;
  logic [15:0] drive_command_word;
  logic [15:0] drive_state_word;
  logic [15:0] target_speed_rpm;
  logic [15:0] speed_demand;
  logic [15:0] speed_actual;
  logic [15:0] accel_ramp_ms;
  logic [15:0] decel_time_ms;
  logic [7:0] operating_mode_select;
  logic [7:0] operating_mode_readback;
  logic [15:0] next_rdata;
  logic next_err;
  logic [15:0] next_state_word;
  logic [15:0] next_setpoint;
  logic [15:0] ramp_rate;
  logic [15:0] init_cnt;
  logic [31:0] comm_cnt;
  logic [31:0] sync_cnt;
  logic [7:0] us_cnt;
  logic [15:0] step_cnt;
  logic comm_armed;
  logic comm_timeout_warning;
  logic card_disconnect_warning;
  logic sync_loss_warning;
  logic sync_loss_fault;
  logic fault_reset_prev;
  logic cause_active;
  logic vel_mode;
  logic running;
  logic powered;
  logic away_from_zero;
  logic us_tick;

  assign cause_active = comm_timeout_warning | card_disconnect_warning |
                        sync_loss_warning | sync_loss_fault;
  assign vel_mode = (operating_mode_select == dps_pkg::MODE_VELOCITY);
  assign running = (state == dps_pkg::ST_OP_ENABLED) && vel_mode &&
                   !drive_command_word[dps_pkg::CW_HALT] &&
                   (drive_command_word[6:4] == dps_pkg::VL_RUN);
  assign powered = (state == dps_pkg::ST_SWITCHED_ON) || (state == dps_pkg::ST_OP_ENABLED) ||
                   (state == dps_pkg::ST_QUICK_STOP) || (state == dps_pkg::ST_FAULT_REACTION);
  assign us_tick = (us_cnt == 8'(dps_pkg::US_CYCLES - 1));

  // ---------------------------------------------------------------
  // Object dictionary access
  // ---------------------------------------------------------------
  // Read data and error decode for the addressed object.
  always_comb
  begin
    next_rdata = dps_pkg::RST_WORD;
    next_err = 1'b0;
    unique case (link.index)
      dps_pkg::IDX_DRIVE_COMMAND_WORD: next_rdata = drive_command_word;
      dps_pkg::IDX_DRIVE_STATE_WORD:
      begin
        next_rdata = drive_state_word;
        next_err = link.we;
      end
      dps_pkg::IDX_TARGET_SPEED_RPM: next_rdata = target_speed_rpm;
      dps_pkg::IDX_SPEED_DEMAND:
      begin
        next_rdata = speed_demand;
        next_err = link.we;
      end
      dps_pkg::IDX_SPEED_ACTUAL:
      begin
        next_rdata = speed_actual;
        next_err = link.we;
      end
      dps_pkg::IDX_ACCEL_RAMP_MS: next_rdata = accel_ramp_ms;
      dps_pkg::IDX_DECEL_TIME_MS: next_rdata = decel_time_ms;
      dps_pkg::IDX_OPERATING_MODE_SELECT:
        next_rdata = {{8{operating_mode_select[7]}}, operating_mode_select};
      dps_pkg::IDX_OPERATING_MODE_READBACK:
      begin
        next_rdata = {{8{operating_mode_readback[7]}}, operating_mode_readback};
        next_err = link.we;
      end
      default: next_err = 1'b1;
    endcase
  end

  // Answer every access one cycle after it is taken.
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      link.ack <= 1'b0;
      link.err <= 1'b0;
      link.rdata <= dps_pkg::RST_WORD;
    end
    else
    begin
      link.ack <= link.req;
      link.err <= link.req & next_err;
      if (link.req)
        link.rdata <= next_rdata;
    end
  end

  // Writable objects; read-only and unknown indices are left untouched.
  // command path
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      drive_command_word <= dps_pkg::RST_WORD;
      target_speed_rpm <= dps_pkg::RST_WORD;
      accel_ramp_ms <= dps_pkg::RST_WORD;
      decel_time_ms <= dps_pkg::RST_WORD;
      operating_mode_select <= dps_pkg::RST_MODE;
    end
    else if (link.req && link.we)
    begin
      unique case (link.index)
        dps_pkg::IDX_DRIVE_COMMAND_WORD: drive_command_word <= link.wdata;
        dps_pkg::IDX_TARGET_SPEED_RPM: target_speed_rpm <= link.wdata;
        dps_pkg::IDX_ACCEL_RAMP_MS: accel_ramp_ms <= link.wdata;
        dps_pkg::IDX_DECEL_TIME_MS: decel_time_ms <= link.wdata;
        dps_pkg::IDX_OPERATING_MODE_SELECT: operating_mode_select <= link.wdata[7:0];
        default: ;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Supervision
  // ---------------------------------------------------------------
  // access watchdog
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      comm_armed <= 1'b0;
      comm_cnt <= 32'h0000_0000;
      comm_timeout_warning <= 1'b0;
    end
    else if (link.req)
    begin
      comm_armed <= 1'b1;
      comm_cnt <= 32'h0000_0000;
      comm_timeout_warning <= 1'b0;
    end
    else if (comm_armed && !comm_timeout_warning)
    begin
      comm_cnt <= comm_cnt + 32'h0000_0001;
      comm_timeout_warning <= (comm_cnt == 32'(COMM_TIMEOUT_CYCLES - 1));
    end
  end

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      sync_cnt <= 32'h0000_0000;
      sync_loss_warning <= 1'b0;
      sync_loss_fault <= 1'b0;
    end
    else if (!sync_mode_en || link.sync_pulse)
    begin
      sync_cnt <= 32'h0000_0000;
      sync_loss_warning <= 1'b0;
      sync_loss_fault <= 1'b0;
    end
    else if (sync_cnt == 32'(SYNC_TIMEOUT_CYCLES - 1))
    begin
      sync_loss_warning <= !cmd_src_card;
      sync_loss_fault <= cmd_src_card;
    end
    else
      sync_cnt <= sync_cnt + 32'h0000_0001;
  end

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      card_disconnect_warning <= 1'b0;
    else
      card_disconnect_warning <= !card_present;
  end

  // ---------------------------------------------------------------
  // Power state machine
  // ---------------------------------------------------------------
  // Next state from the command word and the supervision causes.
  always_comb
  begin
    next_state = state;
    unique case (state)
      dps_pkg::ST_START: next_state = dps_pkg::ST_NOT_READY;
      dps_pkg::ST_NOT_READY:
        if (init_cnt == 16'(dps_pkg::INIT_CYCLES - 1))
          next_state = dps_pkg::ST_ON_DISABLED;
      dps_pkg::ST_ON_DISABLED:
        if (drive_command_word[3:0] == dps_pkg::CMD_SHUTDOWN)
          next_state = dps_pkg::ST_READY;
      dps_pkg::ST_READY:
        if (!drive_command_word[dps_pkg::CW_ENABLE_VOLTAGE])
          next_state = dps_pkg::ST_ON_DISABLED;
        else if (drive_command_word[3:0] == dps_pkg::CMD_SWITCH_ON ||
                 drive_command_word[3:0] == dps_pkg::CMD_SWITCH_ON_ALT)
          next_state = dps_pkg::ST_SWITCHED_ON;
        else if (drive_command_word[3:0] == dps_pkg::CMD_ENABLE_OP)
          next_state = dps_pkg::ST_OP_ENABLED;
      dps_pkg::ST_SWITCHED_ON:
        if (!drive_command_word[dps_pkg::CW_ENABLE_VOLTAGE] ||
            !drive_command_word[dps_pkg::CW_QUICK_STOP])
          next_state = dps_pkg::ST_ON_DISABLED;
        else if (drive_command_word[3:0] == dps_pkg::CMD_SHUTDOWN)
          next_state = dps_pkg::ST_READY;
        else if (drive_command_word[3:0] == dps_pkg::CMD_ENABLE_OP)
          next_state = dps_pkg::ST_OP_ENABLED;
      dps_pkg::ST_OP_ENABLED:
        if (!drive_command_word[dps_pkg::CW_ENABLE_VOLTAGE])
          next_state = dps_pkg::ST_ON_DISABLED;
        else if (!drive_command_word[dps_pkg::CW_QUICK_STOP])
          next_state = dps_pkg::ST_QUICK_STOP;
        else if (drive_command_word[3:0] == dps_pkg::CMD_SHUTDOWN)
          next_state = dps_pkg::ST_READY;
        else if (drive_command_word[3:0] == dps_pkg::CMD_SWITCH_ON ||
                 drive_command_word[3:0] == dps_pkg::CMD_SWITCH_ON_ALT)
          next_state = dps_pkg::ST_SWITCHED_ON;
      dps_pkg::ST_QUICK_STOP:
        if (!drive_command_word[dps_pkg::CW_ENABLE_VOLTAGE])
          next_state = dps_pkg::ST_ON_DISABLED;
      dps_pkg::ST_FAULT_REACTION:
        if (speed_demand == dps_pkg::RST_WORD)
          next_state = dps_pkg::ST_FAULT;
      dps_pkg::ST_FAULT:
        if (drive_command_word[dps_pkg::CW_FAULT_RESET] && !fault_reset_prev && !cause_active)
          next_state = dps_pkg::ST_ON_DISABLED;
      default: next_state = dps_pkg::ST_FAULT;
    endcase
    if (cause_active && state != dps_pkg::ST_START && state != dps_pkg::ST_NOT_READY &&
        state != dps_pkg::ST_FAULT_REACTION && state != dps_pkg::ST_FAULT)
      next_state = dps_pkg::ST_FAULT_REACTION;
  end

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state <= dps_pkg::ST_START;
      init_cnt <= 16'h0000;
      fault_reset_prev <= 1'b0;
    end
    else
    begin
      state <= next_state;
      fault_reset_prev <= drive_command_word[dps_pkg::CW_FAULT_RESET];
      if (state == dps_pkg::ST_NOT_READY)
        init_cnt <= init_cnt + 16'h0001;
    end
  end

  // ---------------------------------------------------------------
  // Velocity ramp
  // ---------------------------------------------------------------
  // Setpoint: only operation enabled in velocity mode takes a reference.
  always_comb
  begin
    next_setpoint = dps_pkg::RST_WORD;
    if (state == dps_pkg::ST_OP_ENABLED && vel_mode && !drive_command_word[dps_pkg::CW_HALT])
    begin
      if (drive_command_word[6:4] == dps_pkg::VL_RUN)
        next_setpoint = target_speed_rpm;
      else if (drive_command_word[6:4] == dps_pkg::VL_HOLD)
        next_setpoint = speed_demand;
    end
    away_from_zero = ($signed(speed_demand) >= 0 && $signed(next_setpoint) > $signed(speed_demand)) ||
                     ($signed(speed_demand) <= 0 && $signed(next_setpoint) < $signed(speed_demand));
    ramp_rate = away_from_zero ? accel_ramp_ms : decel_time_ms;
  end

  // One RPM step every ramp-time plus one microseconds, so 1000 RPM take the ramp time plus 1 ms.
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      us_cnt <= 8'h00;
      step_cnt <= 16'h0000;
      speed_demand <= dps_pkg::RST_WORD;
    end
    else
    begin
      us_cnt <= us_tick ? 8'h00 : us_cnt + 8'h01;
      if (!powered || speed_demand == next_setpoint)
      begin
        step_cnt <= 16'h0000;
        if (!powered)
          speed_demand <= dps_pkg::RST_WORD;
      end
      else if (us_tick)
      begin
        if (step_cnt >= ramp_rate)
        begin
          step_cnt <= 16'h0000;
          if ($signed(next_setpoint) > $signed(speed_demand))
            speed_demand <= speed_demand + 16'h0001;
          else
            speed_demand <= speed_demand - 16'h0001;
        end
        else
          step_cnt <= step_cnt + 16'h0001;
      end
    end
  end

  // ---------------------------------------------------------------
  // State word and outputs
  // ---------------------------------------------------------------
  // state word
  always_comb
  begin
    next_state_word = dps_pkg::RST_WORD;
    next_state_word[dps_pkg::SW_REMOTE] = 1'b1;
    next_state_word[dps_pkg::SW_WARNING] = cause_active;
    next_state_word[dps_pkg::SW_TARGET_REACHED] = running && (speed_demand == target_speed_rpm);
    unique case (state)
      dps_pkg::ST_ON_DISABLED: next_state_word[dps_pkg::SW_ON_DISABLED] = 1'b1;
      dps_pkg::ST_READY: next_state_word[5:0] = 6'h31;
      dps_pkg::ST_SWITCHED_ON: next_state_word[5:0] = 6'h33;
      dps_pkg::ST_OP_ENABLED: next_state_word[5:0] = 6'h37;
      dps_pkg::ST_QUICK_STOP: next_state_word[5:0] = 6'h17;
      dps_pkg::ST_FAULT_REACTION: next_state_word[5:0] = 6'h1F;
      dps_pkg::ST_FAULT: next_state_word[dps_pkg::SW_FAULT] = 1'b1;
      default: ;
    endcase
  end

  // Registered outputs and observed values.
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      drive_state_word <= dps_pkg::RST_WORD;
      speed_actual <= dps_pkg::RST_WORD;
      operating_mode_readback <= dps_pkg::RST_MODE;
      pwm_enable <= 1'b0;
      motor_excited <= 1'b0;
      speed_cmd <= dps_pkg::RST_WORD;
      drive_state <= 4'h0;
      event_code <= dps_pkg::CODE_NONE;
    end
    else
    begin
      drive_state_word <= next_state_word;
      speed_actual <= speed_feedback;
      operating_mode_readback <= operating_mode_select;
      pwm_enable <= powered;
      motor_excited <= powered;
      speed_cmd <= speed_demand;
      drive_state <= state;
      if (sync_loss_fault)
        event_code <= dps_pkg::CODE_SYNC_FAULT;
      else if (sync_loss_warning)
        event_code <= dps_pkg::CODE_SYNC_WARNING;
      else if (card_disconnect_warning)
        event_code <= dps_pkg::CODE_CARD_DISCONNECT;
      else if (comm_timeout_warning)
        event_code <= dps_pkg::CODE_COMM_TIMEOUT;
      else
        event_code <= dps_pkg::CODE_NONE;
    end
  end
endmodule // dps_drive_end
`default_nettype wire

// ==== logic/dps_host_end.sv ====
// Host end: forwards user object accesses onto the link and emits sync packets.
`default_nettype none
module dps_host_end #(
  parameter int SYNC_PERIOD_CYCLES = dps_pkg::SYNC_PERIOD_CYCLES
) (
  input wire logic ref_clk,
  input wire logic resetn,
  dps_link_if.host link,
  input wire logic cmd_valid,
  input wire logic cmd_write,
  input wire logic [15:0] cmd_index,
  input wire logic [15:0] cmd_wdata,
  input wire logic sync_enable,
  output logic cmd_ready,
  output logic rsp_valid,
  output logic rsp_err,
  output logic [15:0] rsp_rdata
);
  logic [31:0] sync_cnt;

  // ---------------------------------------------------------------
  // Access forwarding
  // ---------------------------------------------------------------
  // One access in flight; the request is a single-cycle pulse.
  // object access
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      link.req <= 1'b0;
      link.we <= 1'b0;
      link.index <= dps_pkg::RST_WORD;
      link.wdata <= dps_pkg::RST_WORD;
      cmd_ready <= 1'b1;
      rsp_valid <= 1'b0;
      rsp_err <= 1'b0;
      rsp_rdata <= dps_pkg::RST_WORD;
    end
    else
    begin
      link.req <= 1'b0;
      rsp_valid <= 1'b0;
      if (cmd_valid && cmd_ready)
      begin
        link.req <= 1'b1;
        link.we <= cmd_write;
        link.index <= cmd_index;
        link.wdata <= cmd_wdata;
        cmd_ready <= 1'b0;
      end
      else if (link.ack)
      begin
        rsp_valid <= 1'b1;
        rsp_err <= link.err;
        rsp_rdata <= link.rdata;
        cmd_ready <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // Sync packets
  // ---------------------------------------------------------------
  // Periodic one-cycle sync pulse while enabled.
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      sync_cnt <= 32'h0000_0000;
      link.sync_pulse <= 1'b0;
    end
    else if (!sync_enable)
    begin
      sync_cnt <= 32'h0000_0000;
      link.sync_pulse <= 1'b0;
    end
    else
    begin
      link.sync_pulse <= (sync_cnt == 32'(SYNC_PERIOD_CYCLES - 1));
      if (sync_cnt == 32'(SYNC_PERIOD_CYCLES - 1))
        sync_cnt <= 32'h0000_0000;
      else
        sync_cnt <= sync_cnt + 32'h0000_0001;
    end
  end
endmodule // dps_host_end
`default_nettype wire

// ==== test/dps_link_monitor.sv ====
// Link protocol checker between the host end and the drive end.
`default_nettype none
module dps_link_monitor (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic req,
  input wire logic we,
  input wire logic [15:0] index,
  input wire logic ack,
  input wire logic err,
  input wire logic sync_pulse
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!resetn);
  // Answers, spacing and refusals seen on the link.
  answer_follows_a: assert property (req |=> ack) else $error("no answer");
  answer_cause_a: assert property (ack |-> $past(req)) else $error("stray answer");
  req_spacing_a: assert property (req |=> !req) else $error("requests too close");
  ack_pulse_a: assert property (ack |=> !ack) else $error("answer too long");
  err_with_ack_a: assert property (err |-> ack) else $error("lone error");
  ro_refused_a: assert property (req && we && index == 16'h6041 |=> err)
    else $error("state word written");
  cmd_taken_a: assert property (req && index == 16'h6040 |=> !err)
    else $error("command refused");
  sync_pulse_a: assert property (sync_pulse |=> !sync_pulse) else $error("long sync");
endmodule // dps_link_monitor
`default_nettype wire

// ==== test/drive_profile_state_machine_tb.sv ====
// Self-checking bench joining the host end and the drive end.
`default_nettype none
module drive_profile_state_machine_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [15:0] CW = 16'h6040;
  localparam logic [15:0] SW = 16'h6041;
  localparam logic [15:0] DEM = 16'h6043;
  logic ref_clk = 1'h0, resetn = 1'h0, cmd_valid = 1'h0, cmd_write = 1'h0, sync_enable = 1'h0;
  logic card_present = 1'h1, sync_mode_en = 1'h0, cmd_src_card = 1'h0;
  logic cmd_ready, rsp_valid, rsp_err, pwm_enable, motor_excited;
  logic [15:0] cmd_index = 16'h0, cmd_wdata = 16'h0, rsp_rdata, speed_cmd;
  logic [3:0] drive_state;
  logic [7:0] event_code;
  int miscompares = 0, checked = 0;
  dps_link_if link ();
  dps_host_end #(.SYNC_PERIOD_CYCLES(50)) i_dps_host_end (.ref_clk, .resetn, .link, .cmd_valid,
    .cmd_write, .cmd_index, .cmd_wdata, .sync_enable, .cmd_ready, .rsp_valid, .rsp_err, .rsp_rdata);
  dps_drive_end #(.COMM_TIMEOUT_CYCLES(200), .SYNC_TIMEOUT_CYCLES(300)) i_dps_drive_end (.ref_clk,
    .resetn, .link, .card_present, .sync_mode_en, .cmd_src_card, .speed_feedback(speed_cmd),
    .pwm_enable, .motor_excited, .speed_cmd, .drive_state, .event_code);
  dps_link_monitor i_dps_link_monitor (.ref_clk, .resetn, .req(link.req), .we(link.we),
    .index(link.index), .ack(link.ack), .err(link.err), .sync_pulse(link.sync_pulse));
  // Free-running system clock.
  initial forever #5 ref_clk = ~ref_clk;
  // Prints the counts and the verdict, then stops.
  task automatic end_of_test();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // Compares a seen value with the expected one.
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // One object access through the host user port.
  task automatic acc(input logic w, input logic [15:0] i, input logic [15:0] d);
    int n;
    n = 0;
    cmd_valid <= 1'h1;
    cmd_write <= w;
    cmd_index <= i;
    cmd_wdata <= d;
    @(posedge ref_clk);
    cmd_valid <= 1'h0;
    do
    begin
      @(posedge ref_clk);
      n++;
    end while (rsp_valid !== 1'h1 && n < 9);
    if (rsp_valid !== 1'h1)
    begin
      chk(16'h0, 16'h1);
      end_of_test();
    end
  endtask
  // Reads an object until its masked value matches; the reads keep the link alive.
  task automatic poll(input logic [15:0] i, input logic [15:0] m, input logic [15:0] v);
    int n;
    n = 0;
    do
    begin
      acc(1'h0, i, 16'h0);
      n++;
    end while ((rsp_rdata & m) !== v && n < 600);
    chk(rsp_rdata & m, v);
    if (n == 600 && (rsp_rdata & m) !== v) end_of_test();
  endtask
  // Power-up and the first two commands.
  task automatic t_power();
    poll(SW, 16'h02FF, 16'h0240);
    chk(16'({motor_excited, pwm_enable}), 16'h0);
    acc(1'h1, CW, 16'h0006);
    chk(16'(cmd_ready), 16'h1);
    poll(SW, 16'h02FF, 16'h0231);
    chk(16'({motor_excited, drive_state}), 16'h0003);
    acc(1'h1, CW, 16'h000E);
    poll(SW, 16'h02FF, 16'h0233);
    chk(16'({pwm_enable, drive_state}), 16'h0014);
    $display("power test done");
  endtask
  // Velocity mode: run, hold, decelerate and quick stop.
  task automatic t_speed();
    acc(1'h1, 16'h6060, 16'h0002);
    acc(1'h1, 16'h6042, 16'h0003);
    acc(1'h1, 16'h604F, 16'h0001);
    acc(1'h1, 16'h6050, 16'h0000);
    acc(1'h0, 16'h604F, 16'h0);
    chk(rsp_rdata, 16'h0001);
    acc(1'h0, 16'h6061, 16'h0);
    chk(rsp_rdata, 16'h0002);
    acc(1'h1, CW, 16'h000F);
    poll(SW, 16'h02FF, 16'h0237);
    acc(1'h1, CW, 16'h007F);
    poll(DEM, 16'hFFFF, 16'h0003);
    poll(SW, 16'h0400, 16'h0400);
    chk(speed_cmd, 16'h0003);
    acc(1'h1, CW, 16'h005F);
    acc(1'h1, 16'h6042, 16'h0007);
    repeat (30) acc(1'h0, DEM, 16'h0);
    chk(rsp_rdata, 16'h0003);
    acc(1'h1, CW, 16'h000F);
    poll(DEM, 16'hFFFF, 16'h0000);
    acc(1'h1, CW, 16'h000B);
    poll(SW, 16'h02FF, 16'h0217);
    acc(1'h1, CW, 16'h0000);
    poll(SW, 16'h02FF, 16'h0240);
    $display("velocity test done");
  endtask
  // Refusal, card loss, fault reset, sync loss and link silence.
  task automatic t_events();
    acc(1'h1, SW, 16'hFFFF);
    chk(16'(rsp_err), 16'h1);
    card_present <= 1'h0;
    poll(SW, 16'h00BF, 16'h0088);
    chk(16'({event_code, pwm_enable, motor_excited}), 16'h0164);
    card_present <= 1'h1;
    acc(1'h1, CW, 16'h0080);
    poll(SW, 16'h02FF, 16'h0240);
    for (int s = 1; s >= 0; s--)
    begin
      cmd_src_card <= s[0];
      sync_mode_en <= 1'h1;
      poll(SW, 16'h0080, 16'h0080);
      chk(16'(event_code), s[0] ? 16'h00A1 : 16'h006F);
      sync_mode_en <= 1'h0;
      poll(SW, 16'h0080, 16'h0000);
    end
    sync_enable <= 1'h1;
    sync_mode_en <= 1'h1;
    repeat (120) acc(1'h0, SW, 16'h0);
    chk(rsp_rdata & 16'h0080, 16'h0000);
    sync_mode_en <= 1'h0;
    repeat (250) @(posedge ref_clk);
    chk(16'(event_code), 16'h0051);
    $display("event test done");
  endtask
  // Reset, then the scenarios in turn.
  initial
  begin
    repeat (4) @(posedge ref_clk);
    resetn <= 1'h1;
    t_power();
    t_speed();
    t_events();
    end_of_test();
  end
endmodule // drive_profile_state_machine_tb
`default_nettype wire
